// File: acss_regs.vh
// Purpose: constants of the channel scan sequencer
// Assumes: byte addresses on the plain register port
// Notes:   definitions only
`ifndef ACSS_REGS_VH
`define ACSS_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define ACSS_OFF_MODE      8'h00
`define ACSS_OFF_CUSTOM    8'h04
`define ACSS_OFF_SEQLEN    8'h08
`define ACSS_OFF_SEQMEM    8'h0c
`define ACSS_OFF_STATUS    8'h10

// ****************************************
// control word fields
// ****************************************
`define ACSS_SEL_BIT       15
`define ACSS_SCAN_HI       14
`define ACSS_SCAN_LO       11
`define ACSS_CHSEL_HI      10
`define ACSS_CHSEL_LO      7
`define ACSS_SEQ_CH_HI     11
`define ACSS_SEQ_CH_LO     8

// ****************************************
// scan codes
// ****************************************
`define ACSS_SCAN_NULL     4'h0
`define ACSS_SCAN_MANUAL   4'h1
`define ACSS_SCAN_REPEAT   4'h2
`define ACSS_SCAN_STD_INT  4'h3
`define ACSS_SCAN_STD_EXT  4'h4
`define ACSS_SCAN_UP_INT   4'h5
`define ACSS_SCAN_UP_EXT   4'h6
`define ACSS_SCAN_CUS_INT  4'h7
`define ACSS_SCAN_CUS_EXT  4'h8
`define ACSS_SCAN_ARB      4'h9
`define ACSS_SCAN_LAST_OK  4'h9

// ****************************************
// reset values and counts
// ****************************************
`define ACSS_MODE_RST      4'h1
`define ACSS_CHSEL_RST     4'h0
`define ACSS_MISC_RST      5'h00
`define ACSS_TOP_CH        4'hf
`define ACSS_REPEAT_CNT    9'h010
`define ACSS_CUSTOM_MAX    9'h010

`endif

// File: acss_seq_mem.v
// Purpose: 256 x 4 store for the arbitrary sequence list
// Assumes: one write port, one read port, same clock
// Notes:   read data are registered, one cycle latency
`timescale 1ns/10ps
`default_nettype none

module acss_seq_mem (
  input  wire       clk_i,
  input  wire       wr_en_i,
  input  wire [7:0] wr_addr_i,
  input  wire [3:0] wr_data_i,
  input  wire [7:0] rd_addr_i,
  output reg  [3:0] rd_data_o
);

  reg [3:0] mem_r [0:255];

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule

`default_nettype wire

// File: acss_scan_seq.v
// Purpose: channel scan sequencer of a multichannel converter
// Assumes: conv_done_i from logic on clk_i; scan_start_i is a pin
// Notes:   one control word per write on the register port
`timescale 1ns/10ps
`default_nettype none
`include "acss_regs.vh"

module acss_scan_seq (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [7:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        scan_start_i,
  input  wire        conv_done_i,
  output reg         conv_req_o,
  output reg  [3:0]  channel_number_code_o,
  output reg         ext_clock_o,
  output reg         avg_allow_o,
  output reg         scan_busy_o,
  output reg         result_push_o,
  output reg  [3:0]  result_chan_o,
  output reg  [4:0]  ctrl_bits_o
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_ISSUE = 2'd2;
  localparam ST_WAIT  = 2'd3;

  // ****************************************
  // register writes
  // ****************************************
  reg  [3:0]  mode_r;
  reg  [3:0]  chsel_r;
  reg  [3:0]  pend_mode_r;
  reg  [3:0]  pend_chsel_r;
  reg         pend_r;
  reg  [15:0] custom_r;
  reg  [7:0]  seq_last_r;
  reg  [1:0]  state_r;
  reg  [3:0]  ch_r;
  reg  [7:0]  idx_r;
  reg  [8:0]  cnt_r;
  reg         start_s1_r;
  reg         start_s2_r;
  reg         start_s3_r;
  wire [3:0]  mem_q;
  wire [3:0]  wr_scan = wdata_i[`ACSS_SCAN_HI:`ACSS_SCAN_LO];
  wire        wr_mode = wr_i && (addr_i == `ACSS_OFF_MODE) && !wdata_i[`ACSS_SEL_BIT];
  wire        wr_seq  = wr_i && (addr_i == `ACSS_OFF_SEQMEM);

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_mode_r  <= `ACSS_MODE_RST;
      pend_chsel_r <= `ACSS_CHSEL_RST;
      pend_r       <= 1'b0;
      ctrl_bits_o  <= `ACSS_MISC_RST;
      custom_r     <= 16'h0000;
      seq_last_r   <= 8'h00;
    end else begin
      if (wr_mode && wr_scan == `ACSS_SCAN_NULL) begin
        ctrl_bits_o <= {wdata_i[6:3], wdata_i[1]};
      end else if (wr_mode && wr_scan <= `ACSS_SCAN_LAST_OK) begin
        pend_mode_r  <= wr_scan;
        pend_chsel_r <= wdata_i[`ACSS_CHSEL_HI:`ACSS_CHSEL_LO];
        ctrl_bits_o  <= {wdata_i[6:3], wdata_i[1]};
        pend_r       <= 1'b1;
      end else if (pend_r && state_r == ST_IDLE) begin
        pend_r <= 1'b0;
      end
      if (wr_i && addr_i == `ACSS_OFF_CUSTOM) begin
        custom_r <= wdata_i;
      end
      if (wr_i && addr_i == `ACSS_OFF_SEQLEN) begin
        seq_last_r <= wdata_i[7:0];
      end
    end
  end

  acss_seq_mem u_mem (
    .clk_i     (clk_i),
    .wr_en_i   (wr_seq),
    .wr_addr_i (wdata_i[7:0]),
    .wr_data_i (wdata_i[`ACSS_SEQ_CH_HI:`ACSS_SEQ_CH_LO]),
    .rd_addr_i (idx_r),
    .rd_data_o (mem_q)
  );

  // ****************************************
  // channel stepping helpers
  // ****************************************
  // lowest enabled channel at or above from; bit 4 flags a hit
  function [4:0] acss_find;
    input [15:0] mask;
    input [4:0]  from;
    integer      i;
    begin
      acss_find = 5'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (mask[i] && i >= from) begin
          acss_find = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  wire [4:0] cus_first = acss_find(custom_r, 5'h00);
  wire [4:0] cus_next  = acss_find(custom_r, {1'b0, ch_r} + 5'h01);
  wire       is_cus    = (mode_r == `ACSS_SCAN_CUS_INT) || (mode_r == `ACSS_SCAN_CUS_EXT);
  wire       is_up     = (mode_r == `ACSS_SCAN_UP_INT) || (mode_r == `ACSS_SCAN_UP_EXT);
  wire       is_std    = (mode_r == `ACSS_SCAN_STD_INT) || (mode_r == `ACSS_SCAN_STD_EXT);
  wire       start_evt = start_s2_r && !start_s3_r;

  reg        can_start;
  reg  [3:0] first_ch;
  reg        last_conv;
  reg  [3:0] next_ch;

  always @* begin
    can_start = 1'b1;
    first_ch  = chsel_r;
    last_conv = 1'b1;
    next_ch   = ch_r + 4'h1;
    case (mode_r)
      `ACSS_SCAN_MANUAL: begin
        last_conv = 1'b1;
      end
      `ACSS_SCAN_REPEAT: begin
        next_ch   = ch_r;
        last_conv = (cnt_r == `ACSS_REPEAT_CNT - 9'h001);
      end
      `ACSS_SCAN_STD_INT, `ACSS_SCAN_STD_EXT: begin
        first_ch  = 4'h0;
        last_conv = (ch_r == chsel_r);
      end
      `ACSS_SCAN_UP_INT, `ACSS_SCAN_UP_EXT: begin
        can_start = (chsel_r <= `ACSS_TOP_CH);
        last_conv = (ch_r == `ACSS_TOP_CH);
      end
      `ACSS_SCAN_CUS_INT, `ACSS_SCAN_CUS_EXT: begin
        can_start = cus_first[4];
        first_ch  = cus_first[3:0];
        next_ch   = cus_next[3:0];
        last_conv = !cus_next[4] || (cnt_r == `ACSS_CUSTOM_MAX - 9'h001);
      end
      `ACSS_SCAN_ARB: begin
        first_ch  = 4'h0;
        last_conv = (idx_r == seq_last_r);
      end
      default: begin
        can_start = 1'b0;
      end
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      start_s3_r <= 1'b0;
      mode_r                <= `ACSS_MODE_RST;
      chsel_r               <= `ACSS_CHSEL_RST;
      state_r               <= ST_IDLE;
      ch_r                  <= 4'h0;
      idx_r                 <= 8'h00;
      cnt_r                 <= 9'h000;
      conv_req_o            <= 1'b0;
      channel_number_code_o <= 4'h0;
      ext_clock_o           <= 1'b0;
      avg_allow_o           <= 1'b0;
      scan_busy_o           <= 1'b0;
      result_push_o         <= 1'b0;
      result_chan_o         <= 4'h0;
    end else begin
      start_s1_r    <= scan_start_i;
      start_s2_r    <= start_s1_r;
      start_s3_r    <= start_s2_r;
      conv_req_o    <= 1'b0;
      result_push_o <= 1'b0;
      // external-clock modes never average
      ext_clock_o <= (mode_r == `ACSS_SCAN_MANUAL) || (mode_r == `ACSS_SCAN_STD_EXT) ||
                     (mode_r == `ACSS_SCAN_UP_EXT) || (mode_r == `ACSS_SCAN_CUS_EXT) ||
                     (mode_r == `ACSS_SCAN_ARB);
      avg_allow_o <= (mode_r == `ACSS_SCAN_REPEAT) || (mode_r == `ACSS_SCAN_STD_INT) ||
                     (mode_r == `ACSS_SCAN_UP_INT) || (mode_r == `ACSS_SCAN_CUS_INT);
      case (state_r)
        ST_IDLE: begin
          scan_busy_o <= 1'b0;
          if (pend_r) begin
            mode_r  <= pend_mode_r;
            chsel_r <= pend_chsel_r;
          end else if (start_evt && can_start) begin
            ch_r        <= first_ch;
            idx_r       <= 8'h00;
            cnt_r       <= 9'h000;
            scan_busy_o <= 1'b1;
            state_r     <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // gives the list memory its read cycle
          state_r <= ST_ISSUE;
        end
        ST_ISSUE: begin
          conv_req_o            <= 1'b1;
          channel_number_code_o <= (mode_r == `ACSS_SCAN_ARB) ? mem_q : ch_r;
          state_r               <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_done_i) begin
            result_push_o <= 1'b1;
            result_chan_o <= channel_number_code_o;
            cnt_r         <= cnt_r + 9'h001;
            if (last_conv) begin
              state_r <= ST_IDLE;
            end else begin
              ch_r    <= next_ch;
              idx_r   <= idx_r + 8'h01;
              state_r <= ST_FETCH;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `ACSS_OFF_MODE:   rdata_o <= {1'b0, mode_r, chsel_r, ctrl_bits_o[4:1], 1'b0, ctrl_bits_o[0], 1'b0};
        `ACSS_OFF_CUSTOM: rdata_o <= custom_r;
        `ACSS_OFF_SEQLEN: rdata_o <= {8'h00, seq_last_r};
        `ACSS_OFF_STATUS: rdata_o <= {scan_busy_o, pend_r, state_r, cnt_r[7:0], channel_number_code_o};
        default:          rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// File: acss_conv_model.sv
// Purpose: converter core that answers conversion requests
// Assumes: one request outstanding at a time
// Notes:   lat_i sets the answer delay, zero is prompt
`timescale 1ns/10ps
`default_nettype none
module acss_conv_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       conv_req_i,
  input  wire logic [3:0] lat_i,
  output var  logic       conv_done_o
);
  logic [3:0] cnt_r;
  logic       run_r;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 4'h0;
      run_r <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      conv_done_o <= 1'b0;
      if (conv_req_i) begin
        run_r <= 1'b1;
        cnt_r <= lat_i;
      end else if (run_r && cnt_r == 4'h0) begin
        run_r <= 1'b0;
        conv_done_o <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: acss_scan_seq_sva.sv
// Purpose: port checks of the scan sequencer
// Assumes: mode writes are not issued in the two cycles before a reserved one
// Notes:   bound to every instance
`timescale 1ns/10ps
`default_nettype none
module acss_scan_chk (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        conv_done_i,
  input wire logic        conv_req_o,
  input wire logic        ext_clock_o,
  input wire logic        avg_allow_o,
  input wire logic        scan_busy_o,
  input wire logic        result_push_o,
  input wire logic [3:0]  result_chan_o,
  input wire logic [3:0]  channel_number_code_o,
  input wire logic [4:0]  ctrl_bits_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_read_zero: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("rdata outside read slot");
  a_push_done: assert property (conv_done_i |=> result_push_o) else $error("no push after done");
  a_push_chan: assert property (result_push_o |-> result_chan_o == channel_number_code_o)
    else $error("push tag differs");
  a_clock_avg: assert property (!(ext_clock_o && avg_allow_o)) else $error("averaging on ext clock");
  a_req_pulse: assert property (conv_req_o |=> !conv_req_o) else $error("request too long");
  a_req_busy: assert property (conv_req_o |-> scan_busy_o) else $error("request while idle");
  a_mode_hold: assert property (scan_busy_o && $past(scan_busy_o) |-> $stable(ext_clock_o) && $stable(avg_allow_o))
    else $error("mode changed in scan");
  a_null_misc: assert property (wr_i && addr_i == 8'h00 && wdata_i[15:11] == 5'h00
    |=> ctrl_bits_o == {$past(wdata_i[6:3]), $past(wdata_i[1])}) else $error("null word misc lost");
  a_high_bit: assert property (wr_i && addr_i == 8'h00 && wdata_i[15] |=> $stable(ctrl_bits_o))
    else $error("bit15 word taken");
  a_resv_keep: assert property (wr_i && addr_i == 8'h00 && !wdata_i[15] && wdata_i[14:11] >= 4'ha
    |-> ##2 ext_clock_o == $past(ext_clock_o, 2) && ctrl_bits_o == $past(ctrl_bits_o, 2))
    else $error("reserved code acted");
endmodule
bind acss_scan_seq acss_scan_chk u_chk (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .conv_done_i,
  .conv_req_o, .ext_clock_o, .avg_allow_o, .scan_busy_o, .result_push_o, .result_chan_o, .channel_number_code_o,
  .ctrl_bits_o);
`default_nettype wire

// File: tb_top.sv
// Purpose: scenario bench of the scan sequencer
// Assumes: 16-channel part, converter model on the far side
// Notes:   expected lists are built from the scan codes
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, scan_start_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o, mask_r = 16'h0000;
  logic [3:0] lat_r = 4'h0, chan, rchan;
  logic conv_done, conv_req, ext, avg, busy, push;
  logic [4:0] ctrl;
  logic [3:0] got[$], exp_q[$], arb_q[$];
  int err_count = 0, checks_done = 0, cyc = 0;
  acss_scan_seq DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .scan_start_i(scan_start_i), .conv_done_i(conv_done),
    .conv_req_o(conv_req), .channel_number_code_o(chan), .ext_clock_o(ext), .avg_allow_o(avg),
    .scan_busy_o(busy), .result_push_o(push), .result_chan_o(rchan), .ctrl_bits_o(ctrl));
  acss_conv_model u_conv (.clk_i(clk_i), .reset_i(reset_i), .conv_req_i(conv_req), .lat_i(lat_r),
    .conv_done_o(conv_done));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (push === 1'b1) got.push_back(rchan);
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  task close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task scan(input logic [3:0] lat);
    int k;
    got.delete();
    @(posedge clk_i);
    lat_r <= lat;
    scan_start_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    scan_start_i <= 1'b0;
    k = 0;
    while (busy !== 1'b1 && k < 20) begin @(posedge clk_i); k++; end
    while (busy === 1'b1 && k < 3000) begin @(posedge clk_i); k++; end
    repeat (2) @(posedge clk_i);
  endtask
  task expect_of(input logic [3:0] code, input logic [3:0] n);
    exp_q.delete();
    for (int i = 0; i < 16; i++) begin
      if ((code == 4'h3 || code == 4'h4) && i <= n) exp_q.push_back(i[3:0]);
      if ((code == 4'h1 && i == n) || code == 4'h2) exp_q.push_back(n);
      if ((code == 4'h5 || code == 4'h6) && i >= n) exp_q.push_back(i[3:0]);
      if ((code == 4'h7 || code == 4'h8) && mask_r[i]) exp_q.push_back(i[3:0]);
    end
    if (code == 4'h9) exp_q = arb_q;
  endtask
  task cmp_scan(input logic [3:0] code);
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got.size()) chk({12'h0, got[i]}, {12'h0, exp_q[i]});
    if (exp_q.size() > 0) chk({12'h0, chan}, {12'h0, exp_q[$]});
    chk({15'h0, ext}, {15'h0, code inside {4'h1, 4'h4, 4'h6, 4'h8, 4'h9}});
    chk({15'h0, avg}, {15'h0, code inside {4'h2, 4'h3, 4'h5, 4'h7}});
  endtask
  task run(input logic [3:0] code, input logic [3:0] n, input logic [3:0] lat, input bit set);
    if (set) wr(8'h00, {1'b0, code, n, 7'h00});
    expect_of(code, n);
    scan(lat);
    cmp_scan(code);
  endtask
  task t_regs;
    rd(8'h00, 16'h0800);
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000);
  endtask
  task t_custom;
    mask_r = 16'h8421;
    wr(8'h04, mask_r);
    run(4'h7, 4'h0, 4'h1, 1);
    mask_r = 16'h0006;
    wr(8'h04, mask_r);
    rd(8'h04, 16'h0006);
    run(4'h8, 4'h0, 4'h0, 1);
  endtask
  task t_arb;
    arb_q = '{4'h7, 4'h2, 4'h7};
    wr(8'h08, 16'h0002);
    foreach (arb_q[i]) wr(8'h0c, {4'h0, arb_q[i], i[7:0]});
    run(4'h9, 4'h0, 4'h2, 1);
    rd(8'h08, 16'h0002);
    rd(8'h10, 16'h0037);
  endtask
  task t_ignored;
    run(4'h4, 4'h3, 4'h0, 1);
    repeat (3) @(posedge clk_i);
    for (int c = 10; c < 16; c++) wr(8'h00, {1'b0, c[3:0], 11'h7ff});
    run(4'h4, 4'h3, 4'h0, 0);
    wr(8'h00, 16'h004a);
    #1 chk({11'h0, ctrl}, 16'h0013);
    repeat (2) @(posedge clk_i);
    wr(8'h00, 16'h8000);
    #1 chk({11'h0, ctrl}, 16'h0013);
    run(4'h4, 4'h3, 4'h1, 0);
  endtask
  task t_midscan;
    expect_of(4'h4, 4'h3);
    fork
      scan(4'h6);
      begin repeat (12) @(posedge clk_i); wr(8'h00, {1'b0, 4'h6, 4'he, 7'h00}); end
    join
    cmp_scan(4'h4);
    run(4'h6, 4'he, 4'h0, 0);
    rd(8'h00, 16'h3700);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    run(4'h4, 4'h3, 4'h0, 1);
    run(4'h5, 4'h0, 4'h2, 1);
    run(4'h6, 4'hf, 4'h5, 1);
    run(4'h3, 4'h2, 4'h1, 1);
    run(4'h1, 4'h9, 4'h0, 1);
    run(4'h2, 4'h5, 4'h0, 1);
    t_custom();
    t_arb();
    t_ignored();
    t_midscan();
    close_out();
  end
endmodule
`default_nettype wire
